// ---- isr_status.v ----
// Overview of operation
// R1: Enabled abnormal events OR into summary bit 3
// R2: Condition register shows live signals, read-only
// R3: Rising/falling filters pass matching condition transitions
// R4: Event latch holds passed transitions, clears on read
// R5: Enable mask gates events into group summary
// R6: Communication events latch, cleared by status query
// R7: Power-on-clear setting clears or keeps comm mask
// R8: Power-on flag bit 7 set each power-up
// R9: Enabled comm events form summary bit 5
// R10: Status byte query shows master bit, clears nothing
// R11: Master summary is unlatched OR of enabled bits
// R12: Service request asserts line, latches request bit
// R13: Serial poll returns request bit, then clears it
// R14: Message queue FIFO; available bit when non-empty
// R15: Reading event clears its derived summary bit
// R16: Both filters set latch both edges
// R17: Host reads summaries, events, then masks cause
// R18: Service mask uses status byte bit weights
// R19: Remote inhibit has latching, live, off modes
// R20: Open-collector fault output with selectable source
// R21: Fault output on/off control overrides source
// R22: Abnormal bits placed at fixed positions
// R23: Enabled operation events form summary bit 7
// R24: Latching inhibit holds until protection clear
// R25: Fault asserts while enabled source bit true
`include "isr_defines.vh"
`default_nettype none

module isr_status #(
  parameter QUEUE_DEPTH = 8,
  parameter QUEUE_AW = 3
) (
  // Clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire cold_rst_i,
  // Host command port
  input wire cmd_valid_i,
  input wire [4:0] cmd_op_i,
  input wire [15:0] cmd_data_i,
  output reg rsp_valid_o,
  output reg [15:0] rsp_data_o,
  // Monitored signals
  input wire overvoltage_trip_i,
  input wire overcurrent_trip_i,
  input wire front_key_flag_i,
  input wire overtemperature_trip_i,
  input wire open_sense_flag_i,
  input wire unregulated_i,
  input wire measurement_overload_flag_i,
  input wire operation_summary_bit_i,
  input wire [6:0] comm_event_i,
  // Output message queue
  input wire msg_push_i,
  input wire [7:0] msg_data_i,
  output wire msg_ready_o,
  input wire msg_pop_i,
  output reg [7:0] msg_data_o,
  output reg msg_valid_o,
  // Pins and service request
  input wire inhibit_pin_i,
  output wire remote_inhibit_active_o,
  output wire fault_pin_o,
  output wire fault_pin_oe_o,
  output wire srq_o
);

  reg [15:0] cond_prev_reg;
  reg [15:0] rise_reg;
  reg [15:0] fall_reg;
  reg [15:0] abn_event_reg;
  reg [15:0] abn_mask_reg;
  reg [7:0] comm_event_reg;
  reg [7:0] comm_mask_reg;
  reg [7:0] sre_reg;
  reg psc_reg;
  reg rqs_reg;
  reg mss_prev_reg;
  reg inh_latch_reg;
  reg [1:0] ri_mode_reg;
  reg [2:0] dfi_src_reg;
  reg dfi_en_reg;
  reg [7:0] queue_mem [0:QUEUE_DEPTH-1];
  reg [QUEUE_AW-1:0] wr_ptr_reg;
  reg [QUEUE_AW-1:0] rd_ptr_reg;
  reg [QUEUE_AW:0] count_reg;

  wire [15:0] cond;
  wire [15:0] abn_pass;
  wire inh_active;
  wire abn_sum;
  wire esb_sum;
  wire message_available_bit;
  wire [7:0] stb_base;
  wire master_summary_bit;
  wire rd_event;
  wire rd_esr;
  wire spoll;
  wire prot_clear;
  wire q_push;
  wire q_pop;
  reg fault_src;

  function [15:0] wr16;
    input [4:0] op;
    begin
      wr16 = 16'h0000;
      wr16[0] = cmd_valid_i && (cmd_op_i == op);
    end
  endfunction

  // R19: inhibit mode select
  // R24: latched, live or ignored
  assign inh_active = (ri_mode_reg == `ISR_RI_LATCH) ? inh_latch_reg :
                      (ri_mode_reg == `ISR_RI_LIVE) ? inhibit_pin_i : 1'b0;
  assign remote_inhibit_active_o = inh_active;

  // R22: live condition bit layout
  // R2: condition follows signals
  assign cond = {1'b0, measurement_overload_flag_i, 3'h0, unregulated_i,
                 inh_active, 3'h0, open_sense_flag_i,
                 overtemperature_trip_i, front_key_flag_i, 1'b0,
                 overcurrent_trip_i, overvoltage_trip_i};

  // R3: transition filters
  // R16: both edges when both set
  assign abn_pass = (cond & ~cond_prev_reg & rise_reg) |
                    (~cond & cond_prev_reg & fall_reg);

  assign rd_event = wr16(`ISR_OP_RD_EVENT) != 16'h0000;
  assign rd_esr = wr16(`ISR_OP_RD_ESR) != 16'h0000;
  assign spoll = wr16(`ISR_OP_SPOLL) != 16'h0000;
  assign prot_clear = wr16(`ISR_OP_PROT_CLEAR) != 16'h0000;

  // R5: mask gates events
  // R1: abnormal summary
  // R15: summary follows latch
  assign abn_sum = |(abn_event_reg & abn_mask_reg);
  // R9: comm event summary
  assign esb_sum = |(comm_event_reg & comm_mask_reg);
  // R14: available when non-empty
  assign message_available_bit = count_reg != {(QUEUE_AW+1){1'b0}};

  // R18: bit weights match mask
  // R23: operation summary bit
  assign stb_base = {operation_summary_bit_i, 1'b0, esb_sum, message_available_bit, abn_sum,
                     3'h0};
  // R11: unlatched master summary
  assign master_summary_bit = |(stb_base & sre_reg);

  // R12: request line follows latch
  assign srq_o = rqs_reg;

  always @* begin
    // R20: fault source select
    case (dfi_src_reg)
      `ISR_DFI_ABN: begin
        fault_src = abn_sum;
      end
      `ISR_DFI_OPS: begin
        fault_src = operation_summary_bit_i;
      end
      `ISR_DFI_ESB: begin
        fault_src = esb_sum;
      end
      `ISR_DFI_RQS: begin
        fault_src = rqs_reg;
      end
      default: begin
        fault_src = 1'b0;
      end
    endcase
  end

  // R21: on/off gate
  // R25: follows source
  assign fault_pin_oe_o = dfi_en_reg && fault_src;
  // R20: open collector pulls low
  assign fault_pin_o = 1'b0;

  assign q_push = msg_push_i && (count_reg != QUEUE_DEPTH[QUEUE_AW:0]);
  assign q_pop = msg_pop_i && message_available_bit;
  assign msg_ready_o = count_reg != QUEUE_DEPTH[QUEUE_AW:0];

  // Nonvolatile settings, survive power cycles; power-on-clear set clears comm mask at power-up
  always @(posedge clk_i) begin
    if (cold_rst_i) begin
      psc_reg <= `ISR_RST_PSC;
      comm_mask_reg <= 8'h00;
    end else if (rst_i) begin
      // R7: power-on-clear of mask
      if (psc_reg) begin
        comm_mask_reg <= 8'h00;
      end
    end else if (cmd_valid_i) begin
      if (cmd_op_i == `ISR_OP_WR_PSC) begin
        psc_reg <= cmd_data_i[0];
      end
      if (cmd_op_i == `ISR_OP_WR_ESE) begin
        comm_mask_reg <= cmd_data_i[7:0];
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cond_prev_reg <= 16'h0000;
      rise_reg <= 16'h0000;
      fall_reg <= 16'h0000;
      abn_event_reg <= 16'h0000;
      abn_mask_reg <= 16'h0000;
      // R8: power-on flag
      comm_event_reg <= 8'h80;
      sre_reg <= 8'h00;
      rqs_reg <= 1'b0;
      mss_prev_reg <= 1'b0;
      inh_latch_reg <= 1'b0;
      ri_mode_reg <= `ISR_RST_RI_MODE;
      dfi_src_reg <= `ISR_RST_DFI_SRC;
      dfi_en_reg <= 1'b0;
    end else begin
      cond_prev_reg <= cond;
      // R4: latch, clear on read, set wins
      abn_event_reg <= (abn_event_reg & {16{~rd_event}}) | abn_pass;
      // R6: comm events, cleared by query
      comm_event_reg <= (comm_event_reg & {8{~rd_esr}}) |
                        {1'b0, comm_event_i};
      mss_prev_reg <= master_summary_bit;
      // R12: latch request on new reason
      // R13: poll clears, set wins
      rqs_reg <= (rqs_reg && !spoll) || (master_summary_bit && !mss_prev_reg);
      // R24: hold until protection clear
      inh_latch_reg <= (inh_latch_reg && !prot_clear) || inhibit_pin_i;
      if (cmd_valid_i) begin
        case (cmd_op_i)
          `ISR_OP_WR_RISE: begin
            rise_reg <= cmd_data_i;
          end
          `ISR_OP_WR_FALL: begin
            fall_reg <= cmd_data_i;
          end
          `ISR_OP_WR_MASK: begin
            abn_mask_reg <= cmd_data_i;
          end
          `ISR_OP_WR_SRE: begin
            sre_reg <= {cmd_data_i[7], 1'b0, cmd_data_i[5:0]};
          end
          `ISR_OP_WR_RI_MODE: begin
            if (cmd_data_i[1:0] != 2'h3) begin
              ri_mode_reg <= cmd_data_i[1:0];
            end
          end
          `ISR_OP_WR_DFI_SRC: begin
            if (cmd_data_i[2:0] <= `ISR_DFI_OFF) begin
              dfi_src_reg <= cmd_data_i[2:0];
            end
          end
          `ISR_OP_WR_DFI_EN: begin
            dfi_en_reg <= cmd_data_i[0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Query answers
  always @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
    end else begin
      rsp_valid_o <= 1'b0;
      if (cmd_valid_i) begin
        rsp_valid_o <= 1'b1;
        case (cmd_op_i)
          `ISR_OP_RD_COND: begin
            rsp_data_o <= cond;
          end
          `ISR_OP_RD_RISE: begin
            rsp_data_o <= rise_reg;
          end
          `ISR_OP_RD_FALL: begin
            rsp_data_o <= fall_reg;
          end
          `ISR_OP_RD_EVENT: begin
            rsp_data_o <= abn_event_reg;
          end
          `ISR_OP_RD_MASK: begin
            rsp_data_o <= abn_mask_reg;
          end
          `ISR_OP_RD_ESE: begin
            rsp_data_o <= {8'h00, comm_mask_reg};
          end
          `ISR_OP_RD_ESR: begin
            rsp_data_o <= {8'h00, comm_event_reg};
          end
          `ISR_OP_RD_SRE: begin
            rsp_data_o <= {8'h00, sre_reg};
          end
          // R10: master bit in 6, no clear
          `ISR_OP_RD_STB: begin
            rsp_data_o <= {8'h00, stb_base[7], master_summary_bit, stb_base[5:0]};
          end
          // R13: poll returns request bit
          `ISR_OP_SPOLL: begin
            rsp_data_o <= {8'h00, stb_base[7], rqs_reg, stb_base[5:0]};
          end
          default: begin
            rsp_valid_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // R14: first-in first-out queue
  always @(posedge clk_i) begin
    if (q_push) begin
      queue_mem[wr_ptr_reg] <= msg_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {QUEUE_AW{1'b0}};
      rd_ptr_reg <= {QUEUE_AW{1'b0}};
      count_reg <= {(QUEUE_AW+1){1'b0}};
      msg_data_o <= 8'h00;
      msg_valid_o <= 1'b0;
    end else begin
      msg_valid_o <= q_pop;
      if (q_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (q_pop) begin
        msg_data_o <= queue_mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (q_push && !q_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (q_pop && !q_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // isr_status

`default_nettype wire

// ---- isr_defines.vh ----
`ifndef ISR_DEFINES_VH
`define ISR_DEFINES_VH

// Command opcodes
`define ISR_OP_NOP        5'h00
`define ISR_OP_RD_COND    5'h01
`define ISR_OP_WR_RISE    5'h02
`define ISR_OP_RD_RISE    5'h03
`define ISR_OP_WR_FALL    5'h04
`define ISR_OP_RD_FALL    5'h05
`define ISR_OP_RD_EVENT   5'h06
`define ISR_OP_WR_MASK    5'h07
`define ISR_OP_RD_MASK    5'h08
`define ISR_OP_WR_ESE     5'h09
`define ISR_OP_RD_ESE     5'h0a
`define ISR_OP_RD_ESR     5'h0b
`define ISR_OP_WR_SRE     5'h0c
`define ISR_OP_RD_SRE     5'h0d
`define ISR_OP_RD_STB     5'h0e
`define ISR_OP_SPOLL      5'h0f
`define ISR_OP_WR_PSC     5'h10
`define ISR_OP_WR_RI_MODE 5'h11
`define ISR_OP_WR_DFI_SRC 5'h12
`define ISR_OP_WR_DFI_EN  5'h13
`define ISR_OP_PROT_CLEAR 5'h14

// Abnormal-condition bit positions
`define ISR_AB_OV    0
`define ISR_AB_OC    1
`define ISR_AB_FP    3
`define ISR_AB_OT    4
`define ISR_AB_OS    5
`define ISR_AB_INH   9
`define ISR_AB_UNREG 10
`define ISR_AB_MOVL  14

// Summary byte bit positions
`define ISR_SB_ABN 3
`define ISR_SB_MAV 4
`define ISR_SB_ESB 5
`define ISR_SB_MSS 6
`define ISR_SB_OPS 7

// Communication event power-on bit
`define ISR_CE_PON 7

// Remote inhibit modes
`define ISR_RI_LATCH 2'h0
`define ISR_RI_LIVE  2'h1
`define ISR_RI_OFF   2'h2

// Fault output sources
`define ISR_DFI_ABN 3'h0
`define ISR_DFI_OPS 3'h1
`define ISR_DFI_ESB 3'h2
`define ISR_DFI_RQS 3'h3
`define ISR_DFI_OFF 3'h4

// Reset values
`define ISR_RST_RI_MODE 2'h0
`define ISR_RST_DFI_SRC 3'h4
`define ISR_RST_PSC     1'b1

`endif

// ---- isr_status_properties.sv ----
`include "isr_defines.vh"
`default_nettype none
module isr_status_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic [4:0] cmd_op_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  // Levels and pins
  input wire logic overvoltage_trip_i,
  input wire logic measurement_overload_flag_i,
  input wire logic operation_summary_bit_i,
  input wire logic inhibit_pin_i,
  input wire logic remote_inhibit_active_o,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe_o,
  input wire logic srq_o
);
  logic [1:0] ri_mode_reg;
  logic [2:0] flt_src_reg;
  logic flt_en_reg;
  logic is_poll;
  logic is_stb;
  logic is_cond;
  assign is_poll = cmd_valid_i && cmd_op_i == `ISR_OP_SPOLL;
  assign is_stb = cmd_valid_i && cmd_op_i == `ISR_OP_RD_STB;
  assign is_cond = cmd_valid_i && cmd_op_i == `ISR_OP_RD_COND;
  // Shadow of mode settings
  always @(posedge clk_i) begin
    if (rst_i) begin
      ri_mode_reg <= `ISR_RST_RI_MODE;
      flt_src_reg <= `ISR_RST_DFI_SRC;
      flt_en_reg <= 1'b0;
    end else if (cmd_valid_i) begin
      if (cmd_op_i == `ISR_OP_WR_RI_MODE && cmd_data_i[1:0] != 2'h3)
        ri_mode_reg <= cmd_data_i[1:0];
      if (cmd_op_i == `ISR_OP_WR_DFI_SRC && cmd_data_i[2:0] <= 3'h4)
        flt_src_reg <= cmd_data_i[2:0];
      if (cmd_op_i == `ISR_OP_WR_DFI_EN)
        flt_en_reg <= cmd_data_i[0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_fault_open_drain: assert property (fault_pin_o == 1'b0)
    else $error("fault pin driven high");
  a_poll_returns_rqs: assert property (is_poll |=> rsp_valid_o
    && rsp_data_o[6] == $past(srq_o)) else $error("poll bit 6 wrong");
  a_stb_keeps_rqs: assert property (is_stb && srq_o |=> srq_o
    && rsp_valid_o && rsp_data_o[15:8] == 8'h00) else $error("stb query");
  a_cond_live_read: assert property (is_cond |=>
    rsp_data_o[0] == $past(overvoltage_trip_i)
    && rsp_data_o[14] == $past(measurement_overload_flag_i)
    && rsp_data_o[9] == $past(remote_inhibit_active_o))
    else $error("condition read wrong");
  a_inhibit_live_mode: assert property (ri_mode_reg == `ISR_RI_LIVE
    |-> remote_inhibit_active_o == inhibit_pin_i) else $error("live mode");
  a_inhibit_off_mode: assert property (ri_mode_reg == `ISR_RI_OFF
    |-> !remote_inhibit_active_o) else $error("off mode");
  a_inhibit_latch_hold: assert property (ri_mode_reg == 2'h0
    && $past(ri_mode_reg) == 2'h0 && !$past(rst_i) && $past(inhibit_pin_i)
    |-> remote_inhibit_active_o) else $error("inhibit not latched");
  a_fault_off_quiet: assert property (!flt_en_reg
    |-> !fault_pin_oe_o) else $error("fault while off");
  a_fault_src_ops: assert property (flt_en_reg && flt_src_reg == 3'h1
    |-> fault_pin_oe_o == operation_summary_bit_i) else $error("fault src");
  c_poll_rqs: cover property (is_poll && srq_o);
  c_fault_on: cover property (fault_pin_oe_o);
  c_inh_held: cover property (remote_inhibit_active_o && !inhibit_pin_i);
endmodule // isr_status_properties

bind isr_status isr_status_properties isr_status_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
  .rsp_data_o(rsp_data_o), .overvoltage_trip_i(overvoltage_trip_i),
  .measurement_overload_flag_i(measurement_overload_flag_i),
  .operation_summary_bit_i(operation_summary_bit_i),
  .inhibit_pin_i(inhibit_pin_i),
  .remote_inhibit_active_o(remote_inhibit_active_o),
  .fault_pin_o(fault_pin_o), .fault_pin_oe_o(fault_pin_oe_o), .srq_o(srq_o)
);
`default_nettype wire

// ---- isr_host_model.sv ----
`default_nettype none
module isr_host_model (
  // Clock
  input wire logic clk_i,
  // Command port
  output logic cmd_valid_o,
  output logic [4:0] cmd_op_o,
  output logic [15:0] cmd_data_o,
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rsp;
  logic got;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 5'h00;
    cmd_data_o = 16'h0000;
  end
  // One command, answer taken at release
  task automatic xfer(input logic [4:0] op, input logic [15:0] d);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_data_o = d;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_op_o = ~op;
    cmd_data_o = ~d;
    got = rsp_valid_i;
    rsp = rsp_data_i;
  endtask
endmodule // isr_host_model
`default_nettype wire

// ---- tb.sv ----
`include "isr_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cold = 1'b1;
  logic [6:0] mon = 7'h00;
  logic [6:0] cev = 7'h00;
  logic ops = 1'b0;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic inhibit_pin = 1'b0;
  logic [7:0] pd = 8'h00;
  wire cv, rv, mr, mv, ia, fo, foe, srq;
  wire [4:0] co;
  wire [15:0] cd, rd;
  wire [7:0] md;
  int bad_count = 0;
  int num_checks = 0;
  always #4 clk_i = ~clk_i;
  isr_status isr_status_i (.clk_i(clk_i), .rst_i(rst_i), .cold_rst_i(cold),
    .cmd_valid_i(cv), .cmd_op_i(co), .cmd_data_i(cd), .rsp_valid_o(rv),
    .rsp_data_o(rd), .overvoltage_trip_i(mon[0]),
    .overcurrent_trip_i(mon[1]), .front_key_flag_i(mon[2]),
    .overtemperature_trip_i(mon[3]), .open_sense_flag_i(mon[4]),
    .unregulated_i(mon[5]), .measurement_overload_flag_i(mon[6]),
    .operation_summary_bit_i(ops), .comm_event_i(cev), .msg_push_i(push),
    .msg_data_i(pd), .msg_ready_o(mr), .msg_pop_i(pop), .msg_data_o(md),
    .msg_valid_o(mv), .inhibit_pin_i(inhibit_pin), .remote_inhibit_active_o(ia),
    .fault_pin_o(fo), .fault_pin_oe_o(foe), .srq_o(srq));
  isr_host_model isr_host_model_i (.clk_i(clk_i), .cmd_valid_o(cv),
    .cmd_op_o(co), .cmd_data_o(cd), .rsp_valid_i(rv), .rsp_data_i(rd));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %0t got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask
  task automatic w(input logic [4:0] op, input logic [15:0] d);
    isr_host_model_i.xfer(op, d);
  endtask
  task automatic q(input logic [4:0] op, input logic [15:0] e);
    isr_host_model_i.xfer(op, 16'h0000);
    chk({15'h0000, isr_host_model_i.got}, 16'h0001);
    chk(isr_host_model_i.rsp, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pwr;
    @(negedge clk_i);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
  endtask
  task automatic t_comm;
    q(`ISR_OP_RD_ESR, 16'h0080);
    q(`ISR_OP_RD_ESR, 16'h0000);
    @(negedge clk_i);
    cev = 7'h10;
    @(negedge clk_i);
    cev = 7'h00;
    q(`ISR_OP_RD_ESR, 16'h0010);
    w(`ISR_OP_WR_ESE, 16'h0080);
    pwr();
    q(`ISR_OP_RD_ESE, 16'h0000);
    w(`ISR_OP_WR_PSC, 16'h0000);
    w(`ISR_OP_WR_ESE, 16'h0080);
    pwr();
    q(`ISR_OP_RD_ESE, 16'h0080);
    w(`ISR_OP_WR_SRE, 16'h0020);
    cyc(3);
    chk({15'h0000, srq}, 16'h0001);
    q(`ISR_OP_RD_STB, 16'h0060);
    q(`ISR_OP_SPOLL, 16'h0060);
    chk({15'h0000, srq}, 16'h0000);
    q(`ISR_OP_RD_ESR, 16'h0080);
    q(`ISR_OP_RD_STB, 16'h0000);
    w(`ISR_OP_WR_SRE, 16'h0000);
    w(`ISR_OP_WR_PSC, 16'h0001);
  endtask
  task automatic t_abn;
    w(`ISR_OP_WR_RI_MODE, 16'h0002);
    mon = 7'h7f;
    q(`ISR_OP_RD_COND, 16'h443b);
    mon = 7'h00;
    w(`ISR_OP_WR_RISE, 16'h0003);
    w(`ISR_OP_WR_MASK, 16'h0001);
    mon = 7'h03;
    cyc(2);
    w(`ISR_OP_WR_SRE, 16'h0088);
    cyc(2);
    chk({15'h0000, srq}, 16'h0001);
    q(`ISR_OP_SPOLL, 16'h0048);
    q(`ISR_OP_RD_EVENT, 16'h0003);
    q(`ISR_OP_RD_EVENT, 16'h0000);
    q(`ISR_OP_RD_STB, 16'h0000);
    w(`ISR_OP_WR_SRE, 16'h0000);
    mon = 7'h00;
    cyc(2);
    mon = 7'h02;
    cyc(2);
    q(`ISR_OP_RD_STB, 16'h0000);
    q(`ISR_OP_RD_EVENT, 16'h0002);
    w(`ISR_OP_WR_RISE, 16'h0400);
    w(`ISR_OP_WR_FALL, 16'h0400);
    mon = 7'h20;
    cyc(2);
    q(`ISR_OP_RD_EVENT, 16'h0400);
    mon = 7'h00;
    cyc(2);
    q(`ISR_OP_RD_EVENT, 16'h0400);
  endtask
  task automatic t_queue;
    @(negedge clk_i);
    push = 1'b1;
    pd = 8'h5a;
    @(negedge clk_i);
    pd = 8'ha5;
    @(negedge clk_i);
    push = 1'b0;
    q(`ISR_OP_RD_STB, 16'h0010);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_i);
      pop = 1'b1;
      @(negedge clk_i);
      pop = 1'b0;
      chk({7'h00, mv, md}, (i == 0) ? 16'h015a : 16'h01a5);
    end
    q(`ISR_OP_RD_STB, 16'h0000);
  endtask
  task automatic t_full;
    @(negedge clk_i);
    push = 1'b1;
    for (int i = 0; i < 9; i++) begin
      pd = {4'h3, i[3:0]};
      @(negedge clk_i);
    end
    push = 1'b0;
    chk({15'h0000, mr}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      pop = 1'b1;
      @(negedge clk_i);
      chk({7'h00, mv, md}, {8'h01, 4'h3, i[3:0]});
    end
    pop = 1'b0;
    chk({15'h0000, mr}, 16'h0001);
    q(`ISR_OP_RD_STB, 16'h0000);
  endtask
  task automatic t_pins;
    w(`ISR_OP_WR_RI_MODE, 16'h0000);
    inhibit_pin = 1'b1;
    cyc(1);
    inhibit_pin = 1'b0;
    cyc(1);
    chk({15'h0000, ia}, 16'h0001);
    w(`ISR_OP_PROT_CLEAR, 16'h0000);
    chk({15'h0000, ia}, 16'h0000);
    w(`ISR_OP_WR_RI_MODE, 16'h0001);
    inhibit_pin = 1'b1;
    cyc(1);
    chk({15'h0000, ia}, 16'h0001);
    inhibit_pin = 1'b0;
    cyc(1);
    chk({15'h0000, ia}, 16'h0000);
    inhibit_pin = 1'b1;
    w(`ISR_OP_WR_RI_MODE, 16'h0002);
    chk({15'h0000, ia}, 16'h0000);
    inhibit_pin = 1'b0;
    ops = 1'b1;
    w(`ISR_OP_WR_DFI_SRC, 16'h0001);
    chk({15'h0000, foe}, 16'h0000);
    w(`ISR_OP_WR_DFI_EN, 16'h0001);
    chk({15'h0000, foe}, 16'h0001);
    ops = 1'b0;
    cyc(1);
    chk({15'h0000, foe}, 16'h0000);
    chk({15'h0000, fo}, 16'h0000);
    w(`ISR_OP_WR_DFI_SRC, 16'h0000);
    w(`ISR_OP_WR_MASK, 16'h0400);
    chk({15'h0000, foe}, 16'h0000);
    mon = 7'h20;
    cyc(2);
    chk({15'h0000, foe}, 16'h0001);
    w(`ISR_OP_WR_DFI_SRC, 16'h0003);
    chk({15'h0000, foe}, 16'h0000);
    w(`ISR_OP_WR_SRE, 16'h0008);
    cyc(1);
    chk({15'h0000, foe}, 16'h0001);
    q(`ISR_OP_SPOLL, 16'h0048);
    chk({15'h0000, foe}, 16'h0000);
    w(`ISR_OP_WR_DFI_SRC, 16'h0002);
    w(`ISR_OP_WR_ESE, 16'h0010);
    chk({15'h0000, foe}, 16'h0000);
    cev = 7'h10;
    cyc(1);
    cev = 7'h00;
    chk({15'h0000, foe}, 16'h0001);
    q(`ISR_OP_RD_ESR, 16'h0010);
    chk({15'h0000, foe}, 16'h0000);
    w(`ISR_OP_WR_DFI_SRC, 16'h0004);
    chk({15'h0000, foe}, 16'h0000);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    test_done();
  end
  initial begin
    cyc(20);
    rst_i = 1'b0;
    cold = 1'b0;
    t_comm();
    t_abn();
    t_queue();
    t_full();
    t_pins();
    test_done();
  end
endmodule // tb
`default_nettype wire
